// ### hdl/ecp_pkg.sv
// ==================================================================
// Shared constants for the PCM serial and cascade pin interface
package ecp_pkg;
  // ================================================================
  // Widths
  localparam int PCM_W          = 8;         // One mu-law code per slot
  localparam int CASC_W         = 16;        // Cascade word, bit 15 is the MSB
  localparam int BITCNT_W       = 4;         // Bit counter inside a slot
  // ================================================================
  // Clock and frame timing
  localparam int CLK_HZ         = 20000000;  // Block clock, 50 ns period
  localparam int FRAME_HZ       = 8000;      // Frame rate of sync and samples
  localparam int GEN_BCLK_HZ    = 256000;    // Rate of the generated bit clock
  // Half period of the generated bit clock; rounded down, so slightly fast
  localparam int BCLK_HALF_CYC  = CLK_HZ / (2 * GEN_BCLK_HZ);
  localparam int BITS_PER_FRAME = GEN_BCLK_HZ / FRAME_HZ;
  localparam int DIV_W          = 7;         // Holds BCLK_HALF_CYC - 1
  localparam int FRM_W          = 5;         // Holds BITS_PER_FRAME - 1
  // ================================================================
  // Positions inside the synchronised pin vector
  localparam int SY_SCK         = 0;         // Serial bit clock
  localparam int SY_FSYNC       = 1;         // Frame sync
  localparam int SY_STROBE      = 2;         // Cascade transfer strobe
  localparam int SY_NEAR        = 3;         // Near-end serial data
  localparam int SY_FAR         = 4;         // Far-end serial data
  localparam int SY_HOWL        = 5;         // Howling-detect control
  localparam int SY_ROLE        = 6;         // Chip role select
  localparam int SY_BUS         = 7;         // Cascade bus, 16 bits from here
  localparam int SY_W           = SY_BUS + CASC_W;
  // ================================================================
  // Reset values
  localparam logic [PCM_W-1:0]  PCM_IDLE  = 8'hFF;   // Mu-law quiet code
  localparam logic [CASC_W-1:0] CASC_ZERO = 16'h0000;
endpackage : ecp_pkg

// ### hdl/ecp_sync_edge.sv
`timescale 1ns/1ps
// ==================================================================
// Two-flop synchroniser with edge detection behind the second flop
module ecp_sync_edge #(
  parameter int W = 8                        // Number of pins synchronised
) (
  input  wire logic         clk_i,           // Block clock
  input  wire logic         reset_n_i,       // Async reset, active low
  input  wire logic         ce_i,            // Freezes all flops when low
  input  wire logic [W-1:0] async_i,         // Raw pins from other domains
  output logic      [W-1:0] level_o,         // Synchronised level
  output logic      [W-1:0] rise_o,          // One-cycle rising pulse
  output logic      [W-1:0] fall_o           // One-cycle falling pulse
);
  // ================================================================
  // State: first flop, second flop, history for edges
  typedef struct packed {
    logic [W-1:0] meta;                      // Read only by the second flop
    logic [W-1:0] sync;                      // Safe level
    logic [W-1:0] prev;                      // Previous safe level
  } ecp_sy_state_t;

  ecp_sy_state_t st_reg;                     // Registered state
  ecp_sy_state_t st_next;                    // Next state

  // Shift the chain by one stage
  always_comb begin
    st_next      = st_reg;
    st_next.meta = async_i;
    st_next.sync = st_reg.meta;
    st_next.prev = st_reg.sync;
  end

  // Held still while the clock enable is low
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  // Edges compare only the second and third stages
  assign level_o = st_reg.sync;
  assign rise_o  = st_reg.sync & ~st_reg.prev;
  assign fall_o  = ~st_reg.sync & st_reg.prev;
endmodule : ecp_sync_edge

// ### hdl/ecp_pcm_cascade_io.sv
`timescale 1ns/1ps
// ==================================================================
module ecp_pcm_cascade_io
  import ecp_pkg::*;
#(
  parameter int HALF_CYC  = BCLK_HALF_CYC,   // Generated bit clock half period
  parameter int FRAME_LEN = BITS_PER_FRAME   // Generated bit clocks per frame
) (
  input  wire logic              clk_i,                  // Block clock
  input  wire logic              reset_n_i,              // Async reset, active low
  input  wire logic              ce_i,                   // Clock enable
  input  wire logic              bit_clk_i,              // Serial bit clock pin
  input  wire logic              frame_sync_i,           // Frame sync pin
  input  wire logic              near_end_pcm_in_i,      // Near-end serial data pin
  input  wire logic              far_end_pcm_in_i,       // Far-end serial data pin
  input  wire logic              howl_detect_ctrl_i,     // Howling control pin
  input  wire logic              chip_role_select_i,     // Role pin, high is slave
  input  wire logic              cascade_transfer_strobe_i, // Cascade strobe pin
  input  wire logic [CASC_W-1:0] cascade_word_bus_i,     // Cascade bus level
  input  wire logic [PCM_W-1:0]  tx_sample_i,            // Core code for transmit
  input  wire logic [PCM_W-1:0]  rx_sample_i,            // Core code for receive
  input  wire logic              casc_send_i,            // Core asks to drive bus
  input  wire logic [CASC_W-1:0] casc_word_i,            // Word to drive
  output logic                   tx_pcm_out_o,           // Transmit serial data
  output logic                   tx_pcm_out_oe_o,        // High while driven
  output logic                   rx_pcm_out_o,           // Receive serial data
  output logic                   rx_pcm_out_oe_o,        // High while driven
  output logic      [CASC_W-1:0] cascade_word_bus_o,     // Bus drive value
  output logic                   cascade_word_bus_oe_o,  // High while driven
  output logic      [PCM_W-1:0]  near_sample_o,          // Captured near-end code
  output logic      [PCM_W-1:0]  far_sample_o,           // Captured far-end code
  output logic                   pcm_valid_o,            // Pulse: codes are new
  output logic      [CASC_W-1:0] casc_word_o,            // Captured cascade word
  output logic                   casc_valid_o,           // Pulse: word captured
  output logic                   howl_enable_o,          // Howling detection on
  output logic                   frame_pulse_gen_o,      // Generated 8 kHz sync
  output logic                   bit_clk_gen_o           // Generated bit clock
);
  // ================================================================
  // Pin synchronisation
  logic [SY_W-1:0] pin_raw;                  // All outside pins together
  logic [SY_W-1:0] pin_lvl;                  // Synchronised levels
  logic [SY_W-1:0] pin_rise;                 // Rising edges
  logic [SY_W-1:0] pin_fall;                 // Falling edges

  assign pin_raw = {cascade_word_bus_i, chip_role_select_i, howl_detect_ctrl_i,
                    far_end_pcm_in_i, near_end_pcm_in_i, cascade_transfer_strobe_i,
                    frame_sync_i, bit_clk_i};

  // Every pin passes two flops before the logic below sees it
  ecp_sync_edge #(.W(SY_W)) u_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .async_i   (pin_raw),
    .level_o   (pin_lvl),
    .rise_o    (pin_rise),
    .fall_o    (pin_fall)
  );

  // ================================================================
  // State
  typedef struct packed {
    logic [PCM_W-1:0]    tx_sh;              // Transmit code of this slot
    logic [PCM_W-1:0]    rx_sh;              // Receive code of this slot
    logic [PCM_W-1:0]    near_sh;            // Near-end bits gathered
    logic [PCM_W-1:0]    far_sh;             // Far-end bits gathered
    logic [BITCNT_W-1:0] bitcnt;             // Falling edges seen in slot
    logic                active;             // Slot in progress
    logic                tx_bit;             // Transmit pin value
    logic                rx_bit;             // Receive pin value
    logic                ser_oe;             // Both serial pins driven
    logic [PCM_W-1:0]    near_word;          // Last complete near-end code
    logic [PCM_W-1:0]    far_word;           // Last complete far-end code
    logic                pcm_valid;          // New codes pulse
    logic [CASC_W-1:0]   casc_out;           // Word on the bus
    logic                casc_oe;            // Bus driven
    logic [CASC_W-1:0]   casc_in;            // Word captured
    logic                casc_valid;         // Capture pulse
    logic                howl_en;            // Howling detection enable
    logic [DIV_W-1:0]    div_cnt;            // Bit clock divider
    logic                bclk_gen;           // Generated bit clock
    logic [FRM_W-1:0]    frm_cnt;            // Bit position in generated frame
    logic                fp_gen;             // Generated frame pulse
  } ecp_state_t;

  ecp_state_t st_reg;                        // Registered state
  ecp_state_t st_next;                       // Next state

  // Pick the bit of a code for a slot position, MSB first
  function automatic logic slot_bit(input logic [PCM_W-1:0]    code,
                                    input logic [BITCNT_W-1:0] pos);
    logic [BITCNT_W-1:0] idx;
    idx      = BITCNT_W'(PCM_W - 1) - pos;
    slot_bit = code[idx[2:0]];
  endfunction : slot_bit

  // Shift one serial bit into a code from the right
  function automatic logic [PCM_W-1:0] shift_in(input logic [PCM_W-1:0] code,
                                                input logic             din);
    shift_in = {code[PCM_W-2:0], din};
  endfunction : shift_in

  // ================================================================
  // Next-state logic
  always_comb begin
    st_next            = st_reg;
    st_next.pcm_valid  = 1'b0;
    st_next.casc_valid = 1'b0;

    // Serial slot: a sync rise opens it, eight falling edges close it
    if (pin_rise[SY_FSYNC]) begin
      st_next.active = 1'b1;
      st_next.bitcnt = '0;
      st_next.tx_sh  = tx_sample_i;
      st_next.rx_sh  = rx_sample_i;
      st_next.tx_bit = tx_sample_i[PCM_W-1]; // First bit out at once
      st_next.rx_bit = rx_sample_i[PCM_W-1];
      st_next.ser_oe = 1'b1;
    end else if (st_reg.active) begin
      if (pin_fall[SY_SCK]) begin
        // Inputs read on the falling edge of the bit clock
        st_next.near_sh = shift_in(st_reg.near_sh, pin_lvl[SY_NEAR]);
        st_next.far_sh  = shift_in(st_reg.far_sh, pin_lvl[SY_FAR]);
        st_next.bitcnt  = st_reg.bitcnt + 1'b1;
        if (st_reg.bitcnt == BITCNT_W'(PCM_W - 1)) begin
          // Slot done: hand codes over and release pins
          st_next.active    = 1'b0;
          st_next.ser_oe    = 1'b0;
          st_next.near_word = shift_in(st_reg.near_sh, pin_lvl[SY_NEAR]);
          st_next.far_word  = shift_in(st_reg.far_sh, pin_lvl[SY_FAR]);
          st_next.pcm_valid = 1'b1;
        end
      end else if (pin_rise[SY_SCK] && st_reg.bitcnt != '0) begin
        // Later bits change on the rising edge, steady for the reader
        st_next.tx_bit = slot_bit(st_reg.tx_sh, st_reg.bitcnt);
        st_next.rx_bit = slot_bit(st_reg.rx_sh, st_reg.bitcnt);
      end
    end

    // Cascade bus: drive until the strobe falls, else capture on it
    if (casc_send_i && !st_reg.casc_oe) begin
      st_next.casc_out = casc_word_i;
      st_next.casc_oe  = 1'b1;
    end else if (pin_fall[SY_STROBE]) begin
      if (st_reg.casc_oe) begin
        // Held across the edge, released just after it
        st_next.casc_oe = 1'b0;
      end else begin
        st_next.casc_in    = pin_lvl[SY_BUS +: CASC_W];
        st_next.casc_valid = 1'b1;
      end
    end

    // Howling control; a slave is expected to see it tied low
    st_next.howl_en = pin_lvl[SY_ROLE] | ~pin_lvl[SY_HOWL];

    // Generated bit clock and frame pulse from the block clock
    if (st_reg.div_cnt == DIV_W'(HALF_CYC - 1)) begin
      st_next.div_cnt  = '0;
      st_next.bclk_gen = ~st_reg.bclk_gen;
      if (st_reg.bclk_gen) begin
        // Count frame position on each falling generated edge
        if (st_reg.frm_cnt == FRM_W'(FRAME_LEN - 1)) begin
          st_next.frm_cnt = '0;
        end else begin
          st_next.frm_cnt = st_reg.frm_cnt + 1'b1;
        end
        st_next.fp_gen = (st_reg.frm_cnt == FRM_W'(FRAME_LEN - 1));
      end
    end else begin
      st_next.div_cnt = st_reg.div_cnt + 1'b1;
    end
  end

  // ================================================================
  // State register; every output below is a flop of it
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg           <= '0;
      st_reg.near_word <= PCM_IDLE;
      st_reg.far_word  <= PCM_IDLE;
      st_reg.casc_out  <= CASC_ZERO;
      st_reg.howl_en   <= 1'b1;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign tx_pcm_out_o          = st_reg.tx_bit;
  assign tx_pcm_out_oe_o       = st_reg.ser_oe;
  assign rx_pcm_out_o          = st_reg.rx_bit;
  assign rx_pcm_out_oe_o       = st_reg.ser_oe;
  assign cascade_word_bus_o    = st_reg.casc_out;
  assign cascade_word_bus_oe_o = st_reg.casc_oe;
  assign near_sample_o         = st_reg.near_word;
  assign far_sample_o          = st_reg.far_word;
  assign pcm_valid_o           = st_reg.pcm_valid;
  assign casc_word_o           = st_reg.casc_in;
  assign casc_valid_o          = st_reg.casc_valid;
  assign howl_enable_o         = st_reg.howl_en;
  assign frame_pulse_gen_o     = st_reg.fp_gen;
  assign bit_clk_gen_o         = st_reg.bclk_gen;

  // ================================================================
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_open;
    ce_i && pin_rise[SY_FSYNC];
  endsequence
  sequence s_last_fall;
    ce_i && st_reg.active && !pin_rise[SY_FSYNC] && pin_fall[SY_SCK]
      && st_reg.bitcnt == BITCNT_W'(PCM_W - 1);
  endsequence

  property p_tx_open;
    s_open |=> tx_pcm_out_oe_o && tx_pcm_out_o == $past(tx_sample_i[PCM_W-1]);
  endproperty
  a_tx_open: assert property (p_tx_open) else $error("tx slot not opened");

  property p_rx_open;
    s_open |=> rx_pcm_out_oe_o && rx_pcm_out_o == $past(rx_sample_i[PCM_W-1]);
  endproperty
  a_rx_open: assert property (p_rx_open) else $error("rx slot not opened");

  property p_release;
    s_last_fall |=> !tx_pcm_out_oe_o && !rx_pcm_out_oe_o && pcm_valid_o;
  endproperty
  a_release: assert property (p_release) else $error("serial pins not released");

  property p_idle_hiz;
    !st_reg.active |-> !tx_pcm_out_oe_o && !rx_pcm_out_oe_o;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz) else $error("serial pin driven idle");

  property p_fall_sample;
    ce_i && st_reg.active && !pin_rise[SY_FSYNC] && pin_fall[SY_SCK]
      |=> st_reg.far_sh[0] == $past(pin_lvl[SY_FAR]);
  endproperty
  a_fall_sample: assert property (p_fall_sample) else $error("far bit not sampled");

  property p_valid_count;
    pcm_valid_o |-> $past(st_reg.bitcnt) == BITCNT_W'(PCM_W - 1);
  endproperty
  a_valid_count: assert property (p_valid_count) else $error("code not 8 bits");

  property p_casc_drive;
    ce_i && casc_send_i && !cascade_word_bus_oe_o
      |=> cascade_word_bus_oe_o && cascade_word_bus_o == $past(casc_word_i);
  endproperty
  a_casc_drive: assert property (p_casc_drive) else $error("bus word not driven");

  property p_casc_capture;
    ce_i && pin_fall[SY_STROBE] && !st_reg.casc_oe && !casc_send_i
      |=> casc_valid_o && casc_word_o == $past(pin_lvl[SY_BUS +: CASC_W]);
  endproperty
  a_casc_capture: assert property (p_casc_capture) else $error("bus word lost");

  property p_howl;
    ce_i && !pin_lvl[SY_ROLE] |=> howl_enable_o == !$past(pin_lvl[SY_HOWL]);
  endproperty
  a_howl: assert property (p_howl) else $error("howl enable wrong");

  property p_gen_frame;
    ce_i && $rose(st_reg.fp_gen) |=> !$rose(st_reg.fp_gen) [*8];
  endproperty
  a_gen_frame: assert property (p_gen_frame) else $error("frame pulse too fast");
endmodule : ecp_pcm_cascade_io

// ### sim/ecp_codec_model.sv
`timescale 1ns/1ps
// ==================================================================
// Codec side of the serial link: bit clock, frame sync, serial codes
module ecp_codec_model (
  input  wire logic clk_i,        // Bench clock, pins move on its edges
  input  wire logic tx_i,         // Transmit serial data from the block
  input  wire logic rx_i,         // Receive serial data from the block
  input  wire logic tx_oe_i,      // Transmit drive enable
  input  wire logic rx_oe_i,      // Receive drive enable
  output logic      bit_clk_o,    // Bit clock, still between frames
  output logic      frame_sync_o, // Frame sync, high for the first bit
  output logic      near_o,       // Near-end serial data
  output logic      far_o         // Far-end serial data
);
  // Idle levels at time zero
  initial begin
    bit_clk_o    = 1'b0;
    frame_sync_o = 1'b0;
    near_o       = 1'b0;
    far_o        = 1'b0;
  end
  // One frame of 8 bits, period 8 clocks; data moves on the rise
  task automatic run_frame(input logic [7:0] near, input logic [7:0] far,
                           output logic [7:0] tx_got, output logic [7:0] rx_got,
                           output int oe_miss);
    oe_miss = 0;
    tx_got  = 8'h00;
    rx_got  = 8'h00;
    @(posedge clk_i);
    frame_sync_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    for (int k = 7; k >= 0; k--) begin
      bit_clk_o <= 1'b1;                   // 400 ns period, kept short for run time
      near_o    <= near[k];
      far_o     <= far[k];
      repeat (4) @(posedge clk_i);
      // Look just before the fall, when the block's bit is settled
      @(negedge clk_i);
      tx_got[k] = tx_i;
      rx_got[k] = rx_i;
      if (!(tx_oe_i === 1'b1 && rx_oe_i === 1'b1)) oe_miss++;
      @(posedge clk_i);
      bit_clk_o    <= 1'b0;
      frame_sync_o <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    // Released lines show the inverse so stale bits cannot pass
    near_o <= ~near[0];
    far_o  <= ~far[0];
  endtask : run_frame
endmodule : ecp_codec_model

// ### sim/ecp_pcm_cascade_io_test.sv
`timescale 1ns/1ps
// ==================================================================
// Self-checking bench with a queue model of expected codes; cascade words checked directly
module ecp_pcm_cascade_io_test;
  import ecp_pkg::*;
  localparam int HALF = 2;                  // Short generated half period
  localparam int FLEN = 4;                  // Short generated frame
  logic clk_i, reset_n_i, ce_i, bit_clk_i, frame_sync_i;
  logic near_end_pcm_in_i, far_end_pcm_in_i, howl_detect_ctrl_i;
  logic chip_role_select_i, cascade_transfer_strobe_i, casc_send_i;
  logic [CASC_W-1:0] cascade_word_bus_i, casc_word_i, tb_bus, cascade_word_bus_o;
  logic [CASC_W-1:0] casc_word_o, w;
  logic [PCM_W-1:0]  tx_sample_i, rx_sample_i, near_sample_o, far_sample_o, tg, rg;
  logic tx_pcm_out_o, tx_pcm_out_oe_o, rx_pcm_out_o, rx_pcm_out_oe_o;
  logic cascade_word_bus_oe_o, pcm_valid_o, casc_valid_o, howl_enable_o;
  logic frame_pulse_gen_o, bit_clk_gen_o;
  logic [31:0] rng;                         // Xorshift state
  logic [7:0]  q[$];                        // Expected near, far, tx, rx
  int n_errors, n_compared, miss, n;
  // Bus wire: whoever enables drives it
  assign cascade_word_bus_i = cascade_word_bus_oe_o ? cascade_word_bus_o : tb_bus;
  ecp_pcm_cascade_io #(.HALF_CYC(HALF), .FRAME_LEN(FLEN)) ecp_pcm_cascade_io_i (
    .clk_i, .reset_n_i, .ce_i, .bit_clk_i, .frame_sync_i, .near_end_pcm_in_i,
    .far_end_pcm_in_i, .howl_detect_ctrl_i, .chip_role_select_i,
    .cascade_transfer_strobe_i, .cascade_word_bus_i, .tx_sample_i, .rx_sample_i,
    .casc_send_i, .casc_word_i, .tx_pcm_out_o, .tx_pcm_out_oe_o, .rx_pcm_out_o,
    .rx_pcm_out_oe_o, .cascade_word_bus_o, .cascade_word_bus_oe_o, .near_sample_o,
    .far_sample_o, .pcm_valid_o, .casc_word_o, .casc_valid_o, .howl_enable_o,
    .frame_pulse_gen_o, .bit_clk_gen_o);
  ecp_codec_model ecp_codec_model_i (
    .clk_i(clk_i), .tx_i(tx_pcm_out_o), .rx_i(rx_pcm_out_o),
    .tx_oe_i(tx_pcm_out_oe_o), .rx_oe_i(rx_pcm_out_oe_o), .bit_clk_o(bit_clk_i),
    .frame_sync_o(frame_sync_i), .near_o(near_end_pcm_in_i), .far_o(far_end_pcm_in_i));
  // ================================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic fail(input string m);
    n_errors++;
    $display("ERROR %0t ns: %s", $time, m);
  endtask : fail
  task automatic chk_code(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) fail($sformatf("code %h expected %h", g, e));
  endtask : chk_code
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) fail($sformatf("word %h expected %h", g, e));
  endtask : chk_word
  task automatic chk_bit(input logic g, input logic e);
    n_compared++;
    if (g !== e) fail($sformatf("bit %b expected %b", g, e));
  endtask : chk_bit
  // Bounded wait for a completion pulse: 0 serial, 1 cascade
  task automatic wait_hi(input int which);
    for (int i = 0; i < 20; i++) begin
      @(negedge clk_i);
      if ((which == 0 ? pcm_valid_o : casc_valid_o) === 1'b1) return;
    end
    fail("no completion pulse");
  endtask : wait_hi
  // Cycles between two rises of a generated output: 0 bit clock, 1 frame
  task automatic meas(input int which, output int cnt);
    logic p, c;
    int rises;
    p = 1'b1;
    rises = 0;
    cnt = 0;
    for (int i = 0; i < 200 && rises < 2; i++) begin
      @(negedge clk_i);
      c = (which == 0) ? bit_clk_gen_o : frame_pulse_gen_o;
      if (rises == 1) cnt++;
      if (c === 1'b1 && p === 1'b0) rises++;
      p = c;
    end
  endtask : meas
  task automatic summarize;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // ================================================================
  // 20 MHz block clock, inside the allowed base range
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Watchdog well beyond the expected run
  initial begin
    #(20000 * 50);
    fail("timeout");
    summarize();
  end
  // ================================================================
  // Main sequence
  initial begin
    n_errors = 0;
    n_compared = 0;
    rng = 32'h0000C300;
    reset_n_i = 1'b0;
    ce_i = 1'b1;
    howl_detect_ctrl_i = 1'b0;
    chip_role_select_i = 1'b0;
    cascade_transfer_strobe_i = 1'b1;
    casc_send_i = 1'b0;
    casc_word_i = 16'h0000;
    tb_bus = 16'h0000;
    tx_sample_i = 8'hFF;
    rx_sample_i = 8'hFF;
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    chk_bit(tx_pcm_out_oe_o | rx_pcm_out_oe_o | cascade_word_bus_oe_o, 1'b0);
    // Serial frames with random codes on all four paths
    for (int f = 0; f < 6; f++) begin
      @(posedge clk_i);
      rng = xs(rng);
      tx_sample_i <= rng[23:16];
      rx_sample_i <= rng[31:24];
      for (int b = 0; b < 4; b++) q.push_back(rng[8*b +: 8]);
      ecp_codec_model_i.run_frame(rng[7:0], rng[15:8], tg, rg, miss);
      wait_hi(0);
      chk_code(near_sample_o, q.pop_front());
      chk_code(far_sample_o, q.pop_front());
      chk_code(tg, q.pop_front());
      chk_code(rg, q.pop_front());
      chk_bit(miss == 0, 1'b1);
      chk_bit(tx_pcm_out_oe_o | rx_pcm_out_oe_o, 1'b0);
    end
    // Cascade receive: word held across the strobe fall
    for (int c = 0; c < 3; c++) begin
      rng = xs(rng);
      @(posedge clk_i);
      tb_bus <= rng[15:0];
      repeat (4) @(posedge clk_i);
      cascade_transfer_strobe_i <= 1'b0;
      wait_hi(1);
      chk_word(casc_word_o, rng[15:0]);
      @(posedge clk_i);
      cascade_transfer_strobe_i <= 1'b1;
      tb_bus <= ~rng[15:0];
    end
    // Cascade send, a refused second request, release on strobe fall
    rng = xs(rng);
    w = rng[31:16];
    @(posedge clk_i);
    casc_send_i <= 1'b1;
    casc_word_i <= w;
    @(posedge clk_i);
    casc_send_i <= 1'b0;
    @(negedge clk_i);
    chk_bit(cascade_word_bus_oe_o, 1'b1);
    chk_word(cascade_word_bus_o, w);
    @(posedge clk_i);
    casc_send_i <= 1'b1;
    casc_word_i <= ~w;
    @(posedge clk_i);
    casc_send_i <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk_word(cascade_word_bus_o, w);
    @(posedge clk_i);
    cascade_transfer_strobe_i <= 1'b0;
    repeat (6) @(negedge clk_i);
    chk_bit(cascade_word_bus_oe_o, 1'b0);
    @(posedge clk_i);
    cascade_transfer_strobe_i <= 1'b1;
    // Howling control: master on, master off, slave tied low
    for (int h = 0; h < 3; h++) begin
      @(posedge clk_i);
      chip_role_select_i <= (h == 2);
      howl_detect_ctrl_i <= (h == 1);
      repeat (6) @(negedge clk_i);
      chk_bit(howl_enable_o, h != 1);
    end
    // Generated bit clock and frame pulse periods
    meas(0, n);
    chk_word(n[15:0], 16'(2 * HALF));
    meas(1, n);
    chk_word(n[15:0], 16'(2 * HALF * FLEN));
    summarize();
  end
endmodule : ecp_pcm_cascade_io_test
